// ===== rtl/cssw_pkg.sv
// Package with register map, field layout, reset values and switch timing.
package cssw_pkg;

  localparam logic [7:0] OFS_OSC_CONTROL = 8'h00;
  localparam logic [7:0] OFS_OSC_TUNING = 8'h04;
  localparam logic [7:0] OFS_TIMER1_CONTROL = 8'h08;

  localparam int CTRL_IDLE_BIT = 7;
  localparam int CTRL_IFS_LSB = 4;
  localparam int CTRL_STARTUP_TIMER_DONE_BIT = 3;
  localparam int CTRL_INTERNAL_FREQ_STABLE_BIT = 2;
  localparam int CTRL_SCS_LSB = 0;
  localparam int TUNE_LOW_FREQ_SOURCE_SELECT_BIT = 7;
  localparam int TUNE_PLLEN_BIT = 6;
  localparam int TUNE_VALUE_LSB = 0;
  localparam int T1_RUN_BIT = 6;
  localparam int T1_OSCEN_BIT = 3;

  localparam logic [1:0] SCS_RESET = 2'h0;
  localparam logic [2:0] IFS_RESET = 3'h4;
  localparam logic [4:0] TUNE_RESET = 5'h00;

  localparam logic [2:0] IFS_FULL_FAST = 3'h7;
  localparam logic [2:0] IFS_LOW_FREQ = 3'h0;
  localparam logic [3:0] CFG_INTERNAL_A = 4'h8;
  localparam logic [3:0] CFG_INTERNAL_B = 4'h9;

  localparam logic [1:0] OLD_PAUSE_TICKS = 2'h2;
  localparam logic [1:0] NEW_PAUSE_TICKS = 2'h3;

  typedef enum logic [1:0] {
    SRC_PRIMARY = 2'b00,
    SRC_SECONDARY = 2'b01,
    SRC_INTERNAL = 2'b10
  } cssw_src_e;

  typedef enum logic [1:0] {
    SW_RUN = 2'b00,
    SW_DRAIN_OLD = 2'b01,
    SW_FILL_NEW = 2'b10
  } cssw_sw_state_e;

  // Maps the two-bit select field onto a source.
  function automatic cssw_src_e cssw_src_of(input logic [1:0] scs);
    if (scs[1]) begin
      return SRC_INTERNAL;
    end
    return scs[0] ? SRC_SECONDARY : SRC_PRIMARY;
  endfunction

endpackage

// ===== rtl/cssw_switch.sv
// Glitch-free switch between three source enables with a paused hand-over.
module cssw_switch (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] src_edge,
  input wire logic [1:0] target_scs,
  output logic device_clk_en,
  output cssw_pkg::cssw_src_e active,
  output logic switching
);

  cssw_pkg::cssw_sw_state_e state, next_state;
  cssw_pkg::cssw_src_e next_active, target;
  logic [1:0] cnt, next_cnt;
  logic act_edge;

  always_comb begin
    target = cssw_pkg::cssw_src_of(target_scs);
    act_edge = src_edge[active];
    next_state = state;
    next_active = active;
    next_cnt = cnt;
    unique case (state)
      cssw_pkg::SW_RUN: begin
        if (target != active) begin
          next_state = cssw_pkg::SW_DRAIN_OLD;
          next_cnt = 2'h0;
        end
      end
      cssw_pkg::SW_DRAIN_OLD: begin
        if (act_edge) begin
          if (cnt == cssw_pkg::OLD_PAUSE_TICKS - 2'h1) begin
            next_state = cssw_pkg::SW_FILL_NEW;
            next_active = target;
            next_cnt = 2'h0;
          end else begin
            next_cnt = cnt + 2'h1;
          end
        end
      end
      cssw_pkg::SW_FILL_NEW: begin
        if (act_edge) begin
          if (cnt == cssw_pkg::NEW_PAUSE_TICKS - 2'h1) begin
            next_state = cssw_pkg::SW_RUN;
          end else begin
            next_cnt = cnt + 2'h1;
          end
        end
      end
      default: begin
        next_state = cssw_pkg::SW_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= cssw_pkg::SW_RUN;
      active <= cssw_pkg::SRC_PRIMARY;
      cnt <= 2'h0;
    end else begin
      state <= next_state;
      active <= next_active;
      cnt <= next_cnt;
    end
  end

  // The device clock is gated off for the whole pause.
  assign device_clk_en = (state == cssw_pkg::SW_RUN) && act_edge;
  assign switching = (state != cssw_pkg::SW_RUN);

  AST_PAUSE_GATED: assert property (@(posedge clk) disable iff (!rst_n)
    (state != cssw_pkg::SW_RUN) |-> !device_clk_en)
    else $error("Device clock pulsed during a source switch.");

  AST_SWITCH_STARTS: assert property (@(posedge clk) disable iff (!rst_n)
    (state == cssw_pkg::SW_RUN && cssw_pkg::cssw_src_of(target_scs) != active) |=> switching)
    else $error("A new source selection did not start a switch.");

  AST_NEW_SOURCE_TAKEN: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(switching) |-> active == $past(active))
    else $error("Active source changed at the end of the pause.");

  CVR_FULL_SWITCH: cover property (@(posedge clk) disable iff (!rst_n)
    $fell(switching));

endmodule

// ===== rtl/cssw_top.sv
// Device clock source selector with AHB-Lite control registers.
module cssw_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic primary_osc_pin,
  input wire logic secondary_osc_pin,
  input wire logic slow_internal_pin,
  input wire logic fast_internal_pin,
  input wire logic fast_internal_ok,
  input wire logic startup_timer_expired,
  input wire logic [3:0] primary_osc_config,
  input wire logic sleep_exec,
  output logic device_clk_en,
  output logic watchdog_clk_en,
  output logic idle_enter,
  output logic sleep_enter,
  output logic pll_enable,
  output logic [4:0] tuning_value
);

  logic rst_meta, rst_n;
  logic [5:0] pin_s1, pin_s2, pin_d;
  logic primary_edge, secondary_edge, slow_edge, fast_edge, fast_ok, ost_done;
  logic [7:0] post_cnt, next_post_cnt, post_mask;
  logic internal_tick, internal_uses_fast;
  logic dp_write, next_dp_write, dp_read, next_dp_read;
  logic [7:0] dp_addr, next_dp_addr;
  logic idle_on_sleep, next_idle_on_sleep;
  logic [2:0] internal_freq_select, next_internal_freq_select;
  logic [1:0] clock_source_select, next_clock_source_select;
  logic low_freq_source_select, next_low_freq_source_select;
  logic pll_request, next_pll_request;
  logic [4:0] next_tuning_value;
  logic secondary_osc_enable, next_secondary_osc_enable;
  logic next_idle_enter, next_sleep_enter;
  logic startup_timer_done, internal_freq_stable, secondary_clock_running;
  logic switching;
  cssw_pkg::cssw_src_e active;
  logic [31:0] wdat;

  // Reset is applied at once and released through two flip-flops.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Oscillator pins and analog status cross in through two flip-flops each.
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pin_s1[gi] <= 1'b0;
          pin_s2[gi] <= 1'b0;
          pin_d[gi] <= 1'b0;
        end else begin
          pin_s1[gi] <= (gi == 0) ? primary_osc_pin :
                        (gi == 1) ? secondary_osc_pin :
                        (gi == 2) ? slow_internal_pin :
                        (gi == 3) ? fast_internal_pin :
                        (gi == 4) ? fast_internal_ok : startup_timer_expired;
          pin_s2[gi] <= pin_s1[gi];
          pin_d[gi] <= pin_s2[gi];
        end
      end
    end
  endgenerate

  assign primary_edge = pin_s2[0] && !pin_d[0];
  assign secondary_edge = pin_s2[1] && !pin_d[1];
  assign slow_edge = pin_s2[2] && !pin_d[2];
  assign fast_edge = pin_s2[3] && !pin_d[3];
  assign fast_ok = pin_s2[4];
  assign ost_done = pin_s2[5];

  // Postscaler mask: code 111 passes every fast edge, each lower code down to 001 halves it, and code 000 passes one in 256.
  function automatic logic [7:0] post_mask_of(input logic [2:0] ifs);
    if (ifs == cssw_pkg::IFS_LOW_FREQ) begin
      return 8'hff;
    end
    return 8'(8'h7f >> ifs);
  endfunction

  always_comb begin
    next_post_cnt = fast_edge ? post_cnt + 8'h01 : post_cnt;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      post_cnt <= 8'h00;
    end else begin
      post_cnt <= next_post_cnt;
    end
  end

  // The internal block output follows the select fields combinationally.
  always_comb begin
    post_mask = post_mask_of(internal_freq_select);
    internal_uses_fast = (internal_freq_select != cssw_pkg::IFS_LOW_FREQ) ||
                         low_freq_source_select;
    if (internal_uses_fast) begin
      internal_tick = fast_edge && ((post_cnt & post_mask) == post_mask);
    end else begin
      internal_tick = slow_edge;
    end
  end

  assign watchdog_clk_en = slow_edge;

  cssw_switch u_switch (
    .clk(clk),
    .rst_n(rst_n),
    .src_edge({internal_tick, secondary_edge, primary_edge}),
    .target_scs(clock_source_select),
    .device_clk_en(device_clk_en),
    .active(active),
    .switching(switching)
  );

  // Status flags are derived from the one active source, so at most one is set.
  assign startup_timer_done = ost_done && !switching &&
                              (active == cssw_pkg::SRC_PRIMARY);
  assign internal_freq_stable = fast_ok && internal_uses_fast && !switching &&
                                (active == cssw_pkg::SRC_INTERNAL);
  assign secondary_clock_running = !switching &&
                                   (active == cssw_pkg::SRC_SECONDARY);

  // The multiplier needs an internal primary mode and one of the two top codes.
  assign pll_enable = pll_request && internal_freq_select[2:1] == 2'b11 &&
                      (primary_osc_config == cssw_pkg::CFG_INTERNAL_A ||
                       primary_osc_config == cssw_pkg::CFG_INTERNAL_B);

  // AHB-Lite slave: zero wait states, always OKAY, word registers.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wdat = hwdata;

  always_comb begin
    next_dp_write = hsel && htrans[1] && hready && hwrite;
    next_dp_read = hsel && htrans[1] && hready && !hwrite;
    next_dp_addr = haddr[7:0];
    next_idle_on_sleep = idle_on_sleep;
    next_internal_freq_select = internal_freq_select;
    next_clock_source_select = clock_source_select;
    next_low_freq_source_select = low_freq_source_select;
    next_pll_request = pll_request;
    next_tuning_value = tuning_value;
    next_secondary_osc_enable = secondary_osc_enable;
    if (dp_write && dp_addr == cssw_pkg::OFS_OSC_CONTROL) begin
      next_idle_on_sleep = wdat[cssw_pkg::CTRL_IDLE_BIT];
      next_internal_freq_select = wdat[cssw_pkg::CTRL_IFS_LSB +: 3];
      if (wdat[cssw_pkg::CTRL_SCS_LSB +: 2] != 2'b01 || secondary_osc_enable) begin
        next_clock_source_select = wdat[cssw_pkg::CTRL_SCS_LSB +: 2];
      end
    end
    if (dp_write && dp_addr == cssw_pkg::OFS_OSC_TUNING) begin
      next_low_freq_source_select = wdat[cssw_pkg::TUNE_LOW_FREQ_SOURCE_SELECT_BIT];
      next_pll_request = wdat[cssw_pkg::TUNE_PLLEN_BIT];
      next_tuning_value = wdat[cssw_pkg::TUNE_VALUE_LSB +: 5];
    end
    if (dp_write && dp_addr == cssw_pkg::OFS_TIMER1_CONTROL) begin
      next_secondary_osc_enable = wdat[cssw_pkg::T1_OSCEN_BIT];
    end
    next_idle_enter = sleep_exec && idle_on_sleep;
    next_sleep_enter = sleep_exec && !idle_on_sleep;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_write <= 1'b0;
      dp_read <= 1'b0;
      dp_addr <= 8'h00;
      idle_on_sleep <= 1'b0;
      internal_freq_select <= cssw_pkg::IFS_RESET;
      clock_source_select <= cssw_pkg::SCS_RESET;
      low_freq_source_select <= 1'b0;
      pll_request <= 1'b0;
      tuning_value <= cssw_pkg::TUNE_RESET;
      secondary_osc_enable <= 1'b0;
      idle_enter <= 1'b0;
      sleep_enter <= 1'b0;
    end else begin
      dp_write <= next_dp_write;
      dp_read <= next_dp_read;
      dp_addr <= next_dp_addr;
      idle_on_sleep <= next_idle_on_sleep;
      internal_freq_select <= next_internal_freq_select;
      clock_source_select <= next_clock_source_select;
      low_freq_source_select <= next_low_freq_source_select;
      pll_request <= next_pll_request;
      tuning_value <= next_tuning_value;
      secondary_osc_enable <= next_secondary_osc_enable;
      idle_enter <= next_idle_enter;
      sleep_enter <= next_sleep_enter;
    end
  end

  // Read data is a mux of registers and live flags during the data phase.
  always_comb begin
    hrdata = 32'h0000_0000;
    if (dp_read) begin
      unique case (dp_addr)
        cssw_pkg::OFS_OSC_CONTROL: begin
          hrdata[cssw_pkg::CTRL_IDLE_BIT] = idle_on_sleep;
          hrdata[cssw_pkg::CTRL_IFS_LSB +: 3] = internal_freq_select;
          hrdata[cssw_pkg::CTRL_STARTUP_TIMER_DONE_BIT] = startup_timer_done;
          hrdata[cssw_pkg::CTRL_INTERNAL_FREQ_STABLE_BIT] = internal_freq_stable;
          hrdata[cssw_pkg::CTRL_SCS_LSB +: 2] = clock_source_select;
        end
        cssw_pkg::OFS_OSC_TUNING: begin
          hrdata[cssw_pkg::TUNE_LOW_FREQ_SOURCE_SELECT_BIT] = low_freq_source_select;
          hrdata[cssw_pkg::TUNE_PLLEN_BIT] = pll_enable;
          hrdata[cssw_pkg::TUNE_VALUE_LSB +: 5] = tuning_value;
        end
        cssw_pkg::OFS_TIMER1_CONTROL: begin
          hrdata[cssw_pkg::T1_RUN_BIT] = secondary_clock_running;
          hrdata[cssw_pkg::T1_OSCEN_BIT] = secondary_osc_enable;
        end
        default: begin
          hrdata = 32'h0000_0000;
        end
      endcase
    end
  end

  AST_RESET_VALUES: assert property (@(posedge clk)
    $rose(rst_n) |-> clock_source_select == 2'h0 && internal_freq_select == 3'h4)
    else $error("Select fields not at reset values after reset.");

  AST_SECONDARY_IGNORED: assert property (@(posedge clk) disable iff (!rst_n)
    (dp_write && dp_addr == 8'h00 && hwdata[1:0] == 2'b01 && !secondary_osc_enable)
    |=> clock_source_select == $past(clock_source_select))
    else $error("Secondary selection taken without oscillator enable.");

  AST_FLAGS_EXCLUSIVE: assert property (@(posedge clk) disable iff (!rst_n)
    $onehot0({startup_timer_done, internal_freq_stable, secondary_clock_running}))
    else $error("More than one source status flag is set.");

  AST_LOW_FREQ_SLOW: assert property (@(posedge clk) disable iff (!rst_n)
    (internal_freq_select == 3'h0 && !low_freq_source_select) |-> internal_tick == watchdog_clk_en)
    else $error("Low-frequency slow selection does not follow the slow source.");

  AST_SLEEP_MODE: assert property (@(posedge clk) disable iff (!rst_n)
    sleep_exec |=> (idle_enter == $past(idle_on_sleep)) && (sleep_enter != idle_enter))
    else $error("Sleep instruction entered the wrong mode.");

  AST_PLL_CODES: assert property (@(posedge clk) disable iff (!rst_n)
    pll_enable |-> internal_freq_select == 3'h7 || internal_freq_select == 3'h6)
    else $error("Multiplier enabled at a low frequency code.");

  AST_RUNNING_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
    secondary_clock_running |-> clock_source_select == 2'b01 || $past(switching, 1) == 1'b0)
    else $error("Secondary running flag set without secondary source.");

  AST_STARTUP_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
    startup_timer_done |-> active == cssw_pkg::SRC_PRIMARY && ost_done && !switching)
    else $error("Start-up flag set while primary is not driving.");

  CVR_IDLE: cover property (@(posedge clk) disable iff (!rst_n) idle_enter);
  CVR_SECONDARY: cover property (@(posedge clk) disable iff (!rst_n) secondary_clock_running);
  CVR_FAST_LOW: cover property (@(posedge clk) disable iff (!rst_n)
    internal_tick && internal_freq_select == 3'h0 && low_freq_source_select);

endmodule

// ===== bench/test_system_clock_source_switch.sv
// Self-checking bench for the clock source switch with a register model.
module test_system_clock_source_switch;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, resetn = 0, hsel = 0, hwrite = 0, fok = 1, stx = 1, slp = 0;
  logic p0 = 0, p1 = 0, p2 = 0, p3 = 0, hrdy, hresp, dce, wce, ide, sle, pll;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic [3:0] cfg = 0;
  logic [4:0] tv;
  logic [15:0] lfsr = 16'd63735;
  int errors = 0, total_checks = 0, m_ctrl = 'h40, m_tune = 0, m_t1 = 0, cnt = 0;

  always #20 clk = ~clk;

  // Oscillator pins with periods of 6, 14, 20 and 4 clock cycles.
  always @(posedge clk) begin
    cnt <= cnt + 1;
    if (cnt % 3 == 0) p0 <= ~p0;
    if (cnt % 7 == 0) p1 <= ~p1;
    if (cnt % 10 == 0) p2 <= ~p2;
    if (cnt % 2 == 0) p3 <= ~p3;
  end

  cssw_top dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hrdy), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hrdy), .hresp(hresp), .primary_osc_pin(p0), .secondary_osc_pin(p1),
    .slow_internal_pin(p2), .fast_internal_pin(p3), .fast_internal_ok(fok),
    .startup_timer_expired(stx), .primary_osc_config(cfg), .sleep_exec(slp),
    .device_clk_en(dce), .watchdog_clk_en(wce), .idle_enter(ide), .sleep_enter(sle),
    .pll_enable(pll), .tuning_value(tv));

  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chkr(input string n, input int lo, input int hi, input int g);
    total_checks++;
    if (g < lo || g > hi) begin
      errors++;
      $display("unexpected %s expected %0d to %0d seen %0d", n, lo, hi, g);
    end
  endtask

  task automatic hw();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hrdy !== 1'b1 && n < 20);
    if (hrdy !== 1'b1) begin
      chk("hready", 1, hrdy);
      summarize();
    end
  endtask

  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hw();
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    hw();
    rd = hrdata;
    chk("hresp", 0, hresp);
  endtask

  function automatic int act();
    return m_ctrl[1] ? 2 : m_ctrl[0];
  endfunction

  function automatic logic [31:0] expv(input int a);
    int s, f;
    s = act();
    f = (m_ctrl >> 4) & 7;
    case (a)
      0: return (m_ctrl & 'hf3) | ((s == 0 && stx) ? 8 : 0)
        | ((s == 2 && fok && (f != 0 || m_tune[7])) ? 4 : 0);
      4: return (m_tune & 'h9f) | ((m_tune[6] && f >= 6 && cfg[3:1] == 3'h4) ? 'h40 : 0);
      8: return m_t1 | (s == 1 ? 'h40 : 0);
      default: return 0;
    endcase
  endfunction

  function automatic int per();
    int f;
    f = (m_ctrl >> 4) & 7;
    if (act() == 0) return 6;
    if (act() == 1) return 14;
    if (f != 0) return 4 << (7 - f);
    return m_tune[7] ? 1024 : 20;
  endfunction

  task automatic wr(input int a, input int d);
    int v;
    bus(a, 1, d);
    v = d & 'hf3;
    if ((v & 3) == 1 && !m_t1[3]) v = (v & 'hfc) | (m_ctrl & 3);
    if (a == 0) m_ctrl = v;
    if (a == 4) m_tune = d & 'hdf;
    if (a == 8) m_t1 = d & 8;
  endtask

  task automatic rdc(input int a);
    bus(a, 0, 0);
    chk("register read", expv(a), rd);
  endtask

  task automatic rate();
    int w, nd, nw, n;
    w = 8 * per();
    n = 0;
    while (dce !== 1'b1 && n < 2100) begin
      @(posedge clk);
      n++;
    end
    if (dce !== 1'b1) begin
      chk("device_clk_en timeout", 1, dce);
      summarize();
    end
    {nd, nw} = 0;
    repeat (w) begin
      @(posedge clk);
      nd += (dce === 1'b1);
      nw += (wce === 1'b1);
    end
    chkr("device_clk_en count", 7, 9, nd);
    chkr("watchdog_clk_en count", w / 20 - 1, w / 20 + 1, nw);
  endtask

  task automatic sw(input int d);
    int to, tn, n, c, nc;
    c = m_ctrl;
    wr(0, d);
    tn = per();
    // The old source drains at the frequency code that the same write sets.
    nc = m_ctrl;
    m_ctrl = (nc & 'hfc) | (c & 3);
    to = per();
    m_ctrl = nc;
    repeat (2) @(posedge clk);
    n = 2;
    while (dce !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chkr("switch pause", to + 3 * tn - 2, 2 * to + 4 * tn + 8, n);
    if (n >= 3000) summarize();
  endtask

  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1;
    repeat (3) @(posedge clk);
    for (int a = 0; a < 16; a += 4) rdc(a);
    wr('hc, 'hff);
    rdc('hc);
    rate();
    wr(0, 'h41);
    rdc(0);
    $display("test reset and refusal done");
    wr(8, 8);
    sw('h41);
    rate();
    rdc(0);
    rdc(8);
    sw('h72);
    for (int f = 7; f >= 0; f--) begin
      wr(0, 'h02 | (f << 4));
      rate();
      rdc(0);
    end
    wr(4, 'h80);
    rate();
    rdc(0);
    fok <= 0;
    repeat (5) @(posedge clk);
    rdc(0);
    fok <= 1;
    wr(4, 0);
    $display("test internal rates done");
    wr(4, 'h40);
    for (int i = 0; i < 4; i++) begin
      cfg <= (i == 3) ? 4'h0 : (i == 1 ? 4'h9 : 4'h8);
      wr(0, 'h02 | ((7 - i + (i == 3 ? 2 : 0)) << 4));
      @(posedge clk);
      chk("pll_enable", expv(4) >> 6 & 1, pll);
      rdc(4);
    end
    repeat (4) begin
      lfsr = nxt(lfsr);
      wr(4, lfsr[7:0]);
      @(posedge clk);
      chk("tuning_value", m_tune & 'h1f, tv);
      rdc(4);
    end
    wr(4, (m_tune & 'hc0) | ((m_tune - 1) & 'h1f));
    rdc(4);
    wr(4, (m_tune & 'hc0) | ((m_tune + 1) & 'h1f));
    rdc(4);
    $display("test pll and tuning done");
    for (int i = 0; i < 2; i++) begin
      wr(0, (m_ctrl & 'h73) | (i << 7));
      slp <= 1;
      @(posedge clk);
      slp <= 0;
      @(posedge clk);
      chk("idle_enter", i, ide);
      chk("sleep_enter", 1 - i, sle);
      @(posedge clk);
      chk("idle and sleep pulse end", 0, {ide, sle});
    end
    $display("test sleep done");
    sw('h40);
    rate();
    rdc(0);
    rdc(8);
    stx <= 0;
    repeat (5) @(posedge clk);
    rdc(0);
    $display("test return to primary done");
    summarize();
  end
endmodule
